// *** pkg/aolm_map_regs.vh ***
`ifndef AOLM_MAP_REGS_VH
`define AOLM_MAP_REGS_VH
`define AOLM_CH_W 12
`define AOLM_BYTE_W 6
`define AOLM_SEL_W 4
`define AOLM_REG_W 16
`define AOLM_NREG 6
`define AOLM_NLANE 16
`define AOLM_NCH 8
`define AOLM_ADDR_W 8
`define AOLM_ADDR_FIRST 8'h50
`define AOLM_ADDR_LAST 8'h55
`define AOLM_FLD0_LSB 0
`define AOLM_FLD1_LSB 4
`define AOLM_FLD2_LSB 8
`define AOLM_FIXED_BIT 15
`define AOLM_PD_BIT 3
`define AOLM_HALF_BIT 0
`define AOLM_CH_MSB 2
`define AOLM_CH_LSB 1
`define AOLM_DEC_W 4
`define AOLM_DEC_ONE 4'h1
`define AOLM_CNT_ZERO 4'h0
`define AOLM_CNT_STEP 4'h1
`define AOLM_RST_50 16'h8210
`define AOLM_RST_51 16'h8543
`define AOLM_RST_52 16'h8876
`define AOLM_RST_53 16'h8567
`define AOLM_RST_54 16'h8234
`define AOLM_RST_55 16'h8801
`endif

// *** logic/aolm_route_store.v ***
`default_nettype none
`include "aolm_map_regs.vh"
module aolm_route_store (
    input  wire                       i_sys_clk,
    input  wire                       i_arst_n,
    input  wire                       i_wr_en,
    input  wire [`AOLM_ADDR_W-1:0]    i_wr_addr,
    input  wire [`AOLM_REG_W-1:0]     i_wr_data,
    output reg  [`AOLM_NREG*`AOLM_REG_W-1:0] o_regs
);
    // power-up table, restored on every reset; even codes on A, odd on B
    localparam [`AOLM_NREG*`AOLM_REG_W-1:0] RST_TABLE = {
        `AOLM_RST_55, `AOLM_RST_54, `AOLM_RST_53, `AOLM_RST_52, `AOLM_RST_51, `AOLM_RST_50};
    integer k;
    always @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_regs <= RST_TABLE;
        end
        else if (i_wr_en && i_wr_addr >= `AOLM_ADDR_FIRST && i_wr_addr <= `AOLM_ADDR_LAST)
        begin
            // top bit forced to one, as the register layout expects
            for (k = 0; k < `AOLM_NREG; k = k + 1)
                if (i_wr_addr == `AOLM_ADDR_FIRST + k[`AOLM_ADDR_W-1:0])
                    o_regs[k*`AOLM_REG_W +: `AOLM_REG_W] <=
                        i_wr_data | (16'h0001 << `AOLM_FIXED_BIT);
        end
    end
endmodule // aolm_route_store
`default_nettype wire

// *** logic/aolm_lane_mapper.v ***
`default_nettype none
`include "aolm_map_regs.vh"
// Operation
// - even codes give low group channels 1-4
// - odd codes give high byte, two-wire
// - top selector bit powers lane down
// - high group even codes give channels 8-5
// - high group odd codes high byte
// - groups isolated; 4-bit selector per lane
// - selectors held at addresses 50h-55h
// - default one-wire: channel k on primary
// - default two-wire: channel k on both
// - one code per decimation factor samples
// - sync resets decimation dividers
// - no sync leaves dividers free-running
// - filter sync enabled after reset
// - select one aligns ramps, not filters
// - sampling never moved by sync
// - fields at 3:0,7:4,11:8; bit15 one
// - one-wire one pair; two-wire two pairs
module aolm_lane_mapper (
    input  wire                                  i_sys_clk,
    input  wire                                  i_arst_n,
    input  wire                                  i_two_wire,
    input  wire                                  i_test_pattern_align_sel,
    input  wire [`AOLM_DEC_W-1:0]                i_decim_factor,
    input  wire                                  i_sync,
    input  wire                                  i_map_wr_en,
    input  wire [`AOLM_ADDR_W-1:0]               i_map_wr_addr,
    input  wire [`AOLM_REG_W-1:0]                i_map_wr_data,
    input  wire                                  i_sample_valid,
    input  wire [`AOLM_NCH*`AOLM_CH_W-1:0]       i_ch_data,
    output reg  [`AOLM_NCH*`AOLM_CH_W-1:0]       o_lane_pair_primary,
    output reg  [`AOLM_NCH*`AOLM_CH_W-1:0]       o_lane_pair_secondary,
    output reg  [`AOLM_NLANE-1:0]                o_lane_enable,
    output reg                                   o_code_valid,
    output reg                                   o_divider_reset,
    output reg                                   o_ramp_align,
    output wire [`AOLM_NREG*`AOLM_REG_W-1:0]     o_map_regs
);
    wire [`AOLM_NREG*`AOLM_REG_W-1:0] regs;
    reg                               sync_meta;
    reg                               sync_sync;
    reg                               sync_prev;
    reg  [`AOLM_DEC_W-1:0]            dec_cnt;
    wire                              sync_rise;
    wire                              code_tick;
    wire                              decim_off;
    wire                              count_full;
    wire [`AOLM_NCH*`AOLM_CH_W-1:0]   next_primary;
    wire [`AOLM_NCH*`AOLM_CH_W-1:0]   next_secondary;
    wire [`AOLM_NLANE-1:0]            next_lane_enable;
    assign o_map_regs = regs;

    aolm_route_store u_store (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_wr_en   (i_map_wr_en),
        .i_wr_addr (i_map_wr_addr),
        .i_wr_data (i_map_wr_data),
        .o_regs    (regs)
    );

    function [`AOLM_SEL_W-1:0] lane_sel;
        input [`AOLM_NREG*`AOLM_REG_W-1:0] r;
        input integer lane;
        integer reg_i;
        integer fld;
        begin
            reg_i = lane / 3;
            fld = (lane % 3) * `AOLM_SEL_W;
            lane_sel = r[reg_i*`AOLM_REG_W + fld +: `AOLM_SEL_W];
        end
    endfunction

    // lane order in the store: low group 1A,1B..4B; high group 5B,5A,6B,6A..8A
    // high group starts after the unused third field of the third register
    function integer store_slot;
        input integer pair;
        input integer secondary;
        begin
            if (pair < 4)
                store_slot = pair * 2 + secondary;
            else
                store_slot = pair * 2 + 2 - secondary;
        end
    endfunction

    function [`AOLM_CH_W-1:0] route_word;
        input [`AOLM_SEL_W-1:0] sel;
        input integer group;
        input [`AOLM_NCH*`AOLM_CH_W-1:0] ch;
        input two_wire;
        integer idx;
        reg [`AOLM_CH_W-1:0] w;
        begin
            idx = sel[`AOLM_CH_MSB:`AOLM_CH_LSB];
            if (group == 0)
                w = ch[idx*`AOLM_CH_W +: `AOLM_CH_W];
            else
                w = ch[(`AOLM_NCH-1-idx)*`AOLM_CH_W +: `AOLM_CH_W];
            // same byte split in high group
            if (two_wire)
            begin
                if (sel[`AOLM_HALF_BIT])
                    route_word = {{`AOLM_BYTE_W{1'b0}}, w[`AOLM_CH_W-1:`AOLM_BYTE_W]};
                else
                    route_word = {{`AOLM_BYTE_W{1'b0}}, w[`AOLM_BYTE_W-1:0]};
            end
            // odd codes are not defined in one-wire; treated as full word
            else
                route_word = w;
        end
    endfunction

    always @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sync_meta <= 1'b0;
            sync_sync <= 1'b0;
            sync_prev <= 1'b0;
        end
        else
        begin
            sync_meta <= i_sync;
            sync_sync <= sync_meta;
            sync_prev <= sync_sync;
        end
    end
    assign sync_rise = sync_sync & ~sync_prev;

    // enabled from reset; ramp path when select high
    always @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_divider_reset <= 1'b0;
            o_ramp_align    <= 1'b0;
        end
        else
        begin
            o_divider_reset <= sync_rise & ~i_test_pattern_align_sel;
            o_ramp_align    <= sync_rise & i_test_pattern_align_sel;
        end
    end

    assign decim_off  = (i_decim_factor <= `AOLM_DEC_ONE);
    assign count_full = (dec_cnt >= i_decim_factor - `AOLM_DEC_ONE);
    assign code_tick  = i_sample_valid && (count_full || decim_off);
    // divider cleared by sync; otherwise free-running
    always @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            dec_cnt <= `AOLM_CNT_ZERO;
        else if (o_divider_reset)
            dec_cnt <= `AOLM_CNT_ZERO;
        else if (code_tick)
            dec_cnt <= `AOLM_CNT_ZERO;
        else if (i_sample_valid)
            dec_cnt <= dec_cnt + `AOLM_CNT_STEP;
    end

    // sampling stays on sample_valid; sync hits dividers and drops a code in the divider reset cycle
    always @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_code_valid <= 1'b0;
        else
            o_code_valid <= code_tick & ~o_divider_reset;
    end

    genvar p;
    generate
        for (p = 0; p < `AOLM_NCH; p = p + 1)
        begin : g_pair
            wire [`AOLM_SEL_W-1:0] sel_a = lane_sel(regs, store_slot(p, 0));
            wire [`AOLM_SEL_W-1:0] sel_b = lane_sel(regs, store_slot(p, 1));
            wire [`AOLM_CH_W-1:0]  word_a = route_word(sel_a, p / 4, i_ch_data, i_two_wire);
            wire [`AOLM_CH_W-1:0]  word_b = route_word(sel_b, p / 4, i_ch_data, i_two_wire);
            assign next_lane_enable[2*p] = ~sel_a[`AOLM_PD_BIT];
            assign next_lane_enable[2*p+1] = ~sel_b[`AOLM_PD_BIT] & i_two_wire;
            // words hold between code ticks so the serialiser sees a steady value
            assign next_primary[p*`AOLM_CH_W +: `AOLM_CH_W] =
                !code_tick ? o_lane_pair_primary[p*`AOLM_CH_W +: `AOLM_CH_W] :
                sel_a[`AOLM_PD_BIT] ? {`AOLM_CH_W{1'b0}} : word_a;
            assign next_secondary[p*`AOLM_CH_W +: `AOLM_CH_W] =
                !code_tick ? o_lane_pair_secondary[p*`AOLM_CH_W +: `AOLM_CH_W] :
                (sel_b[`AOLM_PD_BIT] || !i_two_wire) ? {`AOLM_CH_W{1'b0}} : word_b;
        end
    endgenerate

    // reset clears words and enables; defaults then follow from the store reset table
    always @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_lane_pair_primary   <= {`AOLM_NCH*`AOLM_CH_W{1'b0}};
            o_lane_pair_secondary <= {`AOLM_NCH*`AOLM_CH_W{1'b0}};
            o_lane_enable         <= {`AOLM_NLANE{1'b0}};
        end
        else
        begin
            o_lane_pair_primary   <= next_primary;
            o_lane_pair_secondary <= next_secondary;
            o_lane_enable         <= next_lane_enable;
        end
    end
endmodule // aolm_lane_mapper
`default_nettype wire

// *** sim/aolm_lane_mapper_sva.sv ***
`default_nettype none
module aolm_chk (
    input wire logic        i_sys_clk,
    input wire logic        i_arst_n,
    input wire logic        i_test_pattern_align_sel,
    input wire logic        i_sync,
    input wire logic        i_map_wr_en,
    input wire logic [7:0]  i_map_wr_addr,
    input wire logic [15:0] i_map_wr_data,
    input wire logic [15:0] o_lane_enable,
    input wire logic        o_code_valid,
    input wire logic        o_divider_reset,
    input wire logic        o_ramp_align,
    input wire logic [95:0] o_map_regs
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);
    AST_DIV_ONE: assert property (o_divider_reset |=> !o_divider_reset)
        else $error("divider reset longer than one cycle");
    AST_RAMP_ONE: assert property (o_ramp_align |=> !o_ramp_align)
        else $error("ramp align longer than one cycle");
    AST_SYNC_DIV: assert property (
        $rose(i_sync) && !i_test_pattern_align_sel |-> ##[2:5] o_divider_reset)
        else $error("no divider reset after sync");
    AST_SYNC_RAMP: assert property (
        $rose(i_sync) && i_test_pattern_align_sel |-> ##[2:5] o_ramp_align)
        else $error("no ramp align after sync");
    AST_SEL_ROUTE: assert property (
        o_divider_reset |-> !o_ramp_align && !$past(i_test_pattern_align_sel))
        else $error("divider reset while pattern align selected");
    AST_FIX15: assert property (o_map_regs[15] && o_map_regs[31] && o_map_regs[47]
        && o_map_regs[63] && o_map_regs[79] && o_map_regs[95]) else $error("bit 15 clear");
    AST_MAP_WR: assert property (
        i_map_wr_en && i_map_wr_addr == 8'h55
        |=> o_map_regs[95:80] == ($past(i_map_wr_data) | 16'h8000))
        else $error("top map register not written");
    AST_BAD_ADDR: assert property (
        i_map_wr_en && (i_map_wr_addr < 8'h50 || i_map_wr_addr > 8'h55) |=> $stable(o_map_regs))
        else $error("write outside map range changed registers");
    AST_LANE_OFF: assert property (
        o_code_valid && !$past(i_map_wr_en) && !$past(i_map_wr_en, 2) && !$past(i_map_wr_en, 3)
        |-> o_lane_enable[0] == !o_map_regs[3]) else $error("lane enable not tied to selector");
endmodule // aolm_chk
bind aolm_lane_mapper aolm_chk u_chk (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_sync(i_sync),
    .i_test_pattern_align_sel(i_test_pattern_align_sel), .i_map_wr_en(i_map_wr_en),
    .i_map_wr_addr(i_map_wr_addr), .i_map_wr_data(i_map_wr_data),
    .o_lane_enable(o_lane_enable), .o_code_valid(o_code_valid),
    .o_divider_reset(o_divider_reset), .o_ramp_align(o_ramp_align), .o_map_regs(o_map_regs));
`default_nettype wire

// *** sim/aolm_rx_model.sv ***
`default_nettype none
module aolm_rx_model (
    input wire logic i_sys_clk,
    input wire logic i_code_valid,
    input wire logic i_divider_reset,
    output var int   o_codes,
    output var int   o_divs
);
    timeunit 1ns;
    timeprecision 1ps;
    // counts only; lane words are judged by the bench, not deserialised here
    initial
    begin
        o_codes = 0;
        o_divs = 0;
    end
    always @(posedge i_sys_clk)
    begin
        if (i_code_valid === 1'b1)
            o_codes <= o_codes + 1;
        if (i_divider_reset === 1'b1)
            o_divs <= o_divs + 1;
    end
endmodule // aolm_rx_model
`default_nettype wire

// *** sim/aolm_lane_mapper_tb.sv ***
`default_nettype none
module aolm_lane_mapper_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [95:0] RST = {16'h8801, 16'h8234, 16'h8567, 16'h8876, 16'h8543, 16'h8210};
    logic clk = 1'b0, rst_n = 1'b0, tw = 1'b0, sel = 1'b0, syn = 1'b0, we = 1'b0, sv = 1'b0;
    logic [3:0] dec = 4'h0;
    logic [7:0] wa = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic [95:0] ch = {12'h8A5, 12'h7A5, 12'h6A5, 12'h5A5, 12'h4A5, 12'h3A5, 12'h2A5, 12'h1A5};
    logic [15:0] en;
    logic [95:0] prim, sec, regs;
    logic cv, dr, ra, t, g;
    logic [3:0] ca, cb;
    logic [9:0] rows [10] = '{10'h201, 10'h223, 10'h245, 10'h267, 10'h301,
                             10'h323, 10'h345, 10'h36F, 10'h049, 10'h168};
    int fail_count = 0, n_checks = 0, cyc = 0, codes, divs, c0, a0, ln;
    always #5 clk = ~clk;
    aolm_lane_mapper dut (
        .i_sys_clk(clk), .i_arst_n(rst_n), .i_two_wire(tw), .i_test_pattern_align_sel(sel),
        .i_decim_factor(dec), .i_sync(syn), .i_map_wr_en(we), .i_map_wr_addr(wa),
        .i_map_wr_data(wd), .i_sample_valid(sv), .i_ch_data(ch), .o_lane_pair_primary(prim),
        .o_lane_pair_secondary(sec), .o_lane_enable(en), .o_code_valid(cv),
        .o_divider_reset(dr), .o_ramp_align(ra), .o_map_regs(regs));
    aolm_rx_model rx (.i_sys_clk(clk), .i_code_valid(cv), .i_divider_reset(dr),
        .o_codes(codes), .o_divs(divs));
    function automatic logic [11:0] expw(input logic a, input logic b, input logic [3:0] c);
        logic [11:0] w;
        w = 12'h0A5 + 12'h100 * (b ? 4'h8 - c[2:1] : c[2:1] + 4'h1);
        if (c[3])
            return 12'h000;
        return !a ? w : c[0] ? {6'h00, w[11:6]} : {6'h00, w[5:0]};
    endfunction
    task automatic chk(input string nm, input logic [95:0] s, input logic [95:0] e);
        n_checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("FAIL %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        we <= 1'b1;
        wa <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
        @(posedge clk);
    endtask
    // one sample; w waits for the emitted code, otherwise just lets it drain
    task automatic pin(input bit w);
        @(posedge clk);
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        for (int k = 0; k < 20 && (w ? cv !== 1'b1 : k < 4); k++) @(posedge clk);
    endtask
    // one-cycle sync pulse, then six cycles for the synchroniser and output pulse
    task automatic sync_pulse();
        @(posedge clk);
        syn <= 1'b1;
        @(posedge clk);
        syn <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("reset regs", regs, RST);
        pin(1);
        chk("default primary", prim, ch);
        chk("default secondary", sec, 96'h0);
        chk("default enable", en, 16'h5555);
        tw <= 1'b1;
        pin(1);
        for (int k = 0; k < 8; k++)
            chk("default pair", {sec[k*12 +: 6], prim[k*12 +: 6]}, ch[k*12 +: 12]);
        chk("default enable two-wire", en, 16'hFFFF);
        foreach (rows[r])
        begin
            {t, g, ca, cb} = rows[r];
            tw <= t;
            wr(g ? 8'h53 : 8'h50, g ? {8'h84, ca, cb} : {8'h84, cb, ca});
            pin(1);
            ln = g ? 48 : 0;
            chk("primary", prim[ln +: 12], expw(t, g, ca));
            chk("secondary", sec[ln +: 12], t ? expw(t, g, cb) : 12'h000);
            if (t)
                chk("enable", en[ln / 6 +: 2], {~cb[3], ~ca[3]});
        end
        wr(8'h55, 16'h0123);
        chk("reg55", regs[95:80], 16'h8123);
        wr(8'h56, 16'h7FFF);
        chk("reg55 kept", regs[95:80], 16'h8123);
        dec <= 4'h2;
        // pattern select held low for filter sync
        a0 = divs;
        sync_pulse();
        c0 = codes;
        repeat (8) pin(0);
        chk("decimated codes", codes - c0, 4);
        chk("divider resets", divs - a0, 1);
        pin(0);
        sync_pulse();
        pin(0);
        chk("realigned codes", codes - c0, 4);
        sel <= 1'b1;
        sync_pulse();
        pin(0);
        chk("ramp sync codes", codes - c0, 5);
        chk("ramp no divider reset", divs - a0, 2);
        sel <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset pulses", {cv, dr, ra}, 3'h0);
        chk("reset enables", en, 16'h0000);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("rereset regs", regs, RST);
        a0 = divs;
        sync_pulse();
        chk("sync after reset", divs - a0, 1);
        report_and_stop();
    end
endmodule // aolm_lane_mapper_tb
`default_nettype wire
